// ==== verilog/cqf_pkg.sv ====
// Constants for the command queue FIFO status block: offsets, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave view; field positions are already converted to LSB-0 numbering.
package cqf_pkg;
   localparam logic [7:0]  OFS_TXQ_STATUS = 8'h3C;
   localparam logic [7:0]  OFS_RXF_STATUS = 8'h40;
   localparam logic [7:0]  OFS_FETCH_CTRL = 8'h44;
   localparam logic [7:0]  OFS_RXF_DATA   = 8'h88;
   localparam logic [7:0]  OFS_TXQ_DATA   = 8'h8C;
   localparam logic [7:0]  OFS_INT_STATUS = 8'h94;
   localparam logic [7:0]  OFS_INT_MASK   = 8'h98;
   // LSB-0 positions of MSB-0 documented bits
   localparam int BIT_FULL     = 31;
   localparam int BIT_AFULL    = 30;
   localparam int BIT_AEMPTY   = 29;
   localparam int BIT_EMPTY    = 28;
   localparam int BIT_PKT_AV   = 26;
   localparam int OCC_LSB      = 16;
   localparam int BIT_FIRST    = 15;
   localparam int BIT_FLUSH    = 12;
   localparam int DEPTH_LSB    = 0;
   localparam int DEPTH_W      = 9;
   localparam int FETCH_LSB    = 16;
   localparam int FETCH_W      = 8;
   localparam int CNT_W        = 10;
   localparam int INT_W        = 4;
   localparam int PKT_QUADLETS = 3;
   localparam logic [31:0] TXQ_STATUS_RESET = 32'h1000_000F;
   localparam logic [31:0] RXF_STATUS_RESET = 32'h1000_004B;
   localparam logic [8:0]  TXQ_DEPTH_RESET  = 9'h00F;
   localparam logic [8:0]  RXF_DEPTH_RESET  = 9'h04B;
   localparam logic [7:0]  FETCH_SIZE_RESET = 8'h08;
   // Interrupt event bits
   localparam int EV_RX_QUADLET = 0;
   localparam int EV_RX_DROP    = 1;
   localparam int EV_TX_DROP    = 2;
   localparam int EV_TX_EMPTIED = 3;
endpackage

// ==== verilog/cqf_top.sv ====
// Command transmit queue and command receive FIFO with status registers on Avalon-MM.
// Assumes bus_reset_in is a synchronous pulse and link-side inputs are synchronous to clk_in.
`timescale 1ns/1ps
module cqf_top #(
   parameter int TXQ_MEM = 16,
   parameter int RXF_MEM = 128
) (
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   input  wire logic                   bus_reset_in,
   // Avalon-MM slave
   input  wire logic [7:0]             avs_address_in,
   input  wire logic                   avs_read_in,
   input  wire logic                   avs_write_in,
   input  wire logic [31:0]            avs_writedata_in,
   output logic      [31:0]            avs_readdata_out,
   output logic                        avs_waitrequest_out,
   // Transmit queue toward the link
   output logic      [31:0]            txq_data_out,
   output logic                        txq_valid_out,
   input  wire logic                   txq_ready_in,
   // Receive FIFO from the link
   input  wire logic [31:0]            rxf_data_in,
   input  wire logic                   rxf_first_in,
   input  wire logic                   rxf_valid_in,
   output logic                        rxf_ready_out,
   // Interrupt
   output logic                        irq_out
);
   import cqf_pkg::*;

   localparam int TA = $clog2(TXQ_MEM);
   localparam int RA = $clog2(RXF_MEM);

   logic [31:0]      tx_mem [TXQ_MEM];
   logic [32:0]      rx_mem [RXF_MEM];
   logic [TA-1:0]    tx_wr, tx_rd;
   logic [RA-1:0]    rx_wr, rx_rd;
   logic [CNT_W-1:0] tx_count, rx_count, tx_cap, rx_cap;
   logic [DEPTH_W-1:0] txq_depth, rxf_depth;
   logic [FETCH_W-1:0] fetch_size;
   logic             txq_flush, rxf_flush;
   logic             txq_full_flag, txq_almost_full_flag, txq_almost_empty_flag, txq_empty_flag;
   logic             txq_packet_available;
   logic             rxf_full_flag, rxf_almost_full_flag, rxf_almost_empty_flag, rxf_empty_flag;
   logic [DEPTH_W-1:0] rxf_occupancy;
   logic             rxf_first_quadlet_marker;
   logic [INT_W-1:0] int_status, int_mask, events;
   logic             req, take, hit_wr, tx_push, tx_pop, rx_push, rx_pop;
   logic [CNT_W-1:0] next_tx_count, next_rx_count;

   // Usable capacity is the programmed depth, bounded by the storage built
   function automatic logic [CNT_W-1:0] cap_of(input logic [DEPTH_W-1:0] d, input int mem);
      logic [CNT_W-1:0] m;
      m = CNT_W'(mem);
      cap_of = ({1'b0, d} > m) ? m : {1'b0, d};
   endfunction

   assign tx_cap = cap_of(txq_depth, TXQ_MEM);
   assign rx_cap = cap_of(rxf_depth, RXF_MEM);

   // Request is taken at the edge where waitrequest is already low
   assign req    = avs_read_in | avs_write_in;
   assign take   = req & ~avs_waitrequest_out;
   assign hit_wr = take & avs_write_in;

   assign tx_push = hit_wr && avs_address_in == OFS_TXQ_DATA && tx_count < tx_cap;
   assign tx_pop  = tx_count != '0 && (!txq_valid_out || txq_ready_in);
   assign rx_push = rxf_valid_in && rxf_ready_out && rx_count < rx_cap;
   assign rx_pop  = take && avs_read_in && avs_address_in == OFS_RXF_DATA && rx_count != '0;

   always_comb begin
      next_tx_count = tx_count + CNT_W'(tx_push) - CNT_W'(tx_pop);
      if (bus_reset_in || txq_flush) begin
         next_tx_count = '0;
      end
   end

   always_comb begin
      next_rx_count = rx_count + CNT_W'(rx_push) - CNT_W'(rx_pop);
      if (bus_reset_in || rxf_flush) begin
         next_rx_count = '0;
      end
   end

   // Transmit storage and pointers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         tx_wr    <= '0;
         tx_rd    <= '0;
         tx_count <= '0;
      end else begin
         tx_count <= next_tx_count;
         if (bus_reset_in || txq_flush) begin
            tx_wr <= '0;
            tx_rd <= '0;
         end else begin
            if (tx_push) begin
               tx_wr <= tx_wr + 1'b1;
            end
            if (tx_pop) begin
               tx_rd <= tx_rd + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (tx_push) begin
         tx_mem[tx_wr] <= avs_writedata_in;
      end
      if (rx_push) begin
         rx_mem[rx_wr] <= {rxf_first_in, rxf_data_in};
      end
   end

   // Output stage toward the link; flushed with the queue
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         txq_valid_out <= 1'b0;
         txq_data_out  <= '0;
      end else if (bus_reset_in || txq_flush) begin
         txq_valid_out <= 1'b0;
      end else if (tx_pop) begin
         txq_valid_out <= 1'b1;
         txq_data_out  <= tx_mem[tx_rd];
      end else if (txq_ready_in) begin
         txq_valid_out <= 1'b0;
      end
   end

   // Receive storage and pointers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rx_wr         <= '0;
         rx_rd         <= '0;
         rx_count      <= '0;
         rxf_ready_out <= 1'b0;
      end else begin
         rx_count      <= next_rx_count;
         rxf_ready_out <= next_rx_count < rx_cap;
         if (bus_reset_in || rxf_flush) begin
            rx_wr <= '0;
            rx_rd <= '0;
         end else begin
            if (rx_push) begin
               rx_wr <= rx_wr + 1'b1;
            end
            if (rx_pop) begin
               rx_rd <= rx_rd + 1'b1;
            end
         end
      end
   end

   // Status flags follow the counts one cycle later
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         txq_full_flag         <= 1'b0;
         txq_almost_full_flag  <= 1'b0;
         txq_almost_empty_flag <= 1'b0;
         txq_empty_flag        <= 1'b1;
         txq_packet_available  <= 1'b0;
         rxf_full_flag         <= 1'b0;
         rxf_almost_full_flag  <= 1'b0;
         rxf_almost_empty_flag <= 1'b0;
         rxf_empty_flag        <= 1'b1;
         rxf_occupancy         <= '0;
      end else if (bus_reset_in) begin
         txq_full_flag         <= 1'b0;
         txq_almost_full_flag  <= 1'b0;
         txq_almost_empty_flag <= 1'b0;
         txq_empty_flag        <= 1'b1;
         txq_packet_available  <= 1'b0;
         rxf_full_flag         <= 1'b0;
         rxf_almost_full_flag  <= 1'b0;
         rxf_almost_empty_flag <= 1'b0;
         rxf_empty_flag        <= 1'b1;
         rxf_occupancy         <= '0;
      end else begin
         txq_full_flag         <= tx_count >= tx_cap;
         txq_almost_full_flag  <= tx_count + CNT_W'(1) == tx_cap;
         txq_almost_empty_flag <= tx_count == CNT_W'(1);
         txq_empty_flag        <= tx_count == '0;
         txq_packet_available  <= tx_cap >= tx_count + CNT_W'(PKT_QUADLETS);
         rxf_full_flag         <= rx_count >= rx_cap;
         rxf_almost_full_flag  <= rx_count + CNT_W'(1) == rx_cap;
         rxf_almost_empty_flag <= rx_count == CNT_W'(1);
         rxf_empty_flag        <= rx_count == '0;
         rxf_occupancy         <= rx_count[DEPTH_W-1:0];
      end
   end

   // First-quadlet marker tracks the quadlet last read from the data port
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rxf_first_quadlet_marker <= 1'b0;
      end else if (bus_reset_in) begin
         rxf_first_quadlet_marker <= 1'b0;
      end else if (rx_pop) begin
         rxf_first_quadlet_marker <= rx_mem[rx_rd][32];
      end
   end

   // Self-clearing flush bits: set by a write of one, cleared once the flush is done
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         txq_flush <= 1'b0;
         rxf_flush <= 1'b0;
      end else if (bus_reset_in) begin
         txq_flush <= 1'b0;
         rxf_flush <= 1'b0;
      end else begin
         txq_flush <= hit_wr && avs_address_in == OFS_TXQ_STATUS && avs_writedata_in[BIT_FLUSH];
         rxf_flush <= hit_wr && avs_address_in == OFS_RXF_STATUS && avs_writedata_in[BIT_FLUSH];
      end
   end

   // Size fields only answer to hardware reset
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         txq_depth  <= TXQ_DEPTH_RESET;
         rxf_depth  <= RXF_DEPTH_RESET;
         fetch_size <= FETCH_SIZE_RESET;
      end else if (hit_wr) begin
         if (avs_address_in == OFS_TXQ_STATUS) begin
            txq_depth <= avs_writedata_in[DEPTH_LSB +: DEPTH_W];
         end
         // A depth below the fetch size would split a fetched block; such writes are dropped
         if (avs_address_in == OFS_RXF_STATUS &&
             avs_writedata_in[DEPTH_LSB +: DEPTH_W] >= {1'b0, fetch_size}) begin
            rxf_depth <= avs_writedata_in[DEPTH_LSB +: DEPTH_W];
         end
         if (avs_address_in == OFS_FETCH_CTRL) begin
            fetch_size <= avs_writedata_in[FETCH_LSB +: FETCH_W];
         end
      end
   end

   // Interrupt events, sticky with set winning over write-one-to-clear
   assign events[EV_RX_QUADLET] = rx_push;
   assign events[EV_RX_DROP]    = rxf_valid_in && !rx_push;
   assign events[EV_TX_DROP]    = hit_wr && avs_address_in == OFS_TXQ_DATA && !tx_push;
   assign events[EV_TX_EMPTIED] = tx_count == CNT_W'(1) && tx_pop && !tx_push;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         int_status <= '0;
         int_mask   <= '0;
         irq_out    <= 1'b0;
      end else begin
         if (hit_wr && avs_address_in == OFS_INT_STATUS) begin
            int_status <= (int_status & ~avs_writedata_in[INT_W-1:0]) | events;
         end else begin
            int_status <= int_status | events;
         end
         if (hit_wr && avs_address_in == OFS_INT_MASK) begin
            int_mask <= avs_writedata_in[INT_W-1:0];
         end
         irq_out <= |(int_status & int_mask);
      end
   end

   // Register read view, reserved bits zero, bit 0 of the word numbering is the LSB
   function automatic logic [31:0] read_view(input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      unique case (a)
         OFS_TXQ_STATUS: begin
            v[BIT_FULL]   = txq_full_flag;
            v[BIT_AFULL]  = txq_almost_full_flag;
            v[BIT_AEMPTY] = txq_almost_empty_flag;
            v[BIT_EMPTY]  = txq_empty_flag;
            v[BIT_PKT_AV] = txq_packet_available;
            v[BIT_FLUSH]  = txq_flush;
            v[DEPTH_LSB +: DEPTH_W] = txq_depth;
         end
         OFS_RXF_STATUS: begin
            v[BIT_FULL]   = rxf_full_flag;
            v[BIT_AFULL]  = rxf_almost_full_flag;
            v[BIT_AEMPTY] = rxf_almost_empty_flag;
            v[BIT_EMPTY]  = rxf_empty_flag;
            v[OCC_LSB +: DEPTH_W] = rxf_occupancy;
            v[BIT_FIRST]  = rxf_first_quadlet_marker;
            v[BIT_FLUSH]  = rxf_flush;
            v[DEPTH_LSB +: DEPTH_W] = rxf_depth;
         end
         OFS_FETCH_CTRL: v[FETCH_LSB +: FETCH_W] = fetch_size;
         OFS_RXF_DATA:   v = (rx_count != '0) ? rx_mem[rx_rd][31:0] : 32'h0000_0000;
         OFS_INT_STATUS: v[INT_W-1:0] = int_status;
         OFS_INT_MASK:   v[INT_W-1:0] = int_mask;
         default:        v = 32'h0000_0000;
      endcase
      read_view = v;
   endfunction

   // One wait cycle per access; read data captured as waitrequest drops
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= '0;
      end else begin
         avs_waitrequest_out <= !(req && avs_waitrequest_out);
         if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= read_view(avs_address_in);
         end
      end
   end

   // Checks
   sequence s_flush_write(logic [7:0] ofs);
      hit_wr && avs_address_in == ofs && avs_writedata_in[BIT_FLUSH];
   endsequence

   a_tx_full_drop: assert property (@(posedge clk_in) disable iff (reset_in)
      (tx_count >= tx_cap && !tx_pop && !txq_flush && !bus_reset_in) |=> tx_count == $past(tx_count))
      else $error("push into full transmit queue");
   a_tx_almost_full: assert property (@(posedge clk_in) disable iff (reset_in)
      !bus_reset_in ##1 !bus_reset_in |-> txq_almost_full_flag == ($past(tx_count) + CNT_W'(1) == $past(tx_cap)))
      else $error("transmit almost-full flag wrong");
   a_tx_almost_empty: assert property (@(posedge clk_in) disable iff (reset_in)
      (!bus_reset_in && tx_count == CNT_W'(1)) |=> txq_almost_empty_flag && !txq_empty_flag)
      else $error("transmit almost-empty flag wrong");
   a_tx_empty_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      bus_reset_in |=> txq_empty_flag && !txq_full_flag && tx_count == '0)
      else $error("bus reset did not empty transmit queue");
   a_tx_pkt_avail: assert property (@(posedge clk_in) disable iff (reset_in)
      (!bus_reset_in && tx_count + CNT_W'(PKT_QUADLETS) > tx_cap) |=> !txq_packet_available)
      else $error("packet available without room");
   a_tx_flush_done: assert property (@(posedge clk_in) disable iff (reset_in)
      s_flush_write(OFS_TXQ_STATUS) ##1 1 |-> txq_flush ##1 (!txq_flush && tx_count == '0 && !txq_valid_out))
      else $error("transmit flush not completed");
   a_depth_keep: assert property (@(posedge clk_in) disable iff (reset_in)
      bus_reset_in && !hit_wr |=> $stable(txq_depth) && $stable(rxf_depth) && $stable(fetch_size))
      else $error("size field changed by bus reset");
   a_rx_full_drop: assert property (@(posedge clk_in) disable iff (reset_in)
      (rx_count >= rx_cap && !rx_pop && !rxf_flush && !bus_reset_in) |=> rx_count == $past(rx_count))
      else $error("push into full receive fifo");
   a_rx_occupancy: assert property (@(posedge clk_in) disable iff (reset_in)
      (!bus_reset_in && !rxf_flush && rx_push && !rx_pop) |=> rx_count == $past(rx_count) + CNT_W'(1)
      ##1 (rxf_occupancy == $past(rx_count[DEPTH_W-1:0]) || $past(bus_reset_in)))
      else $error("occupancy not tracking");
   a_rx_flush_done: assert property (@(posedge clk_in) disable iff (reset_in)
      s_flush_write(OFS_RXF_STATUS) |=> rxf_flush ##1 (!rxf_flush && rx_count == '0))
      else $error("receive flush not completed");
   a_rx_depth_floor: assert property (@(posedge clk_in) disable iff (reset_in)
      (hit_wr && avs_address_in == OFS_RXF_STATUS && avs_writedata_in[DEPTH_LSB +: DEPTH_W] < {1'b0, fetch_size})
      |=> $stable(rxf_depth)) else $error("receive depth below fetch size");
   a_bus_wait: assert property (@(posedge clk_in) disable iff (reset_in)
      req && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("waitrequest timing wrong");

   sequence s_both_cleared;
      txq_empty_flag && rxf_empty_flag && !rxf_first_quadlet_marker && !txq_flush && !rxf_flush;
   endsequence

   a_rx_almost_full: assert property (@(posedge clk_in) disable iff (reset_in)
      (!bus_reset_in && rx_count + CNT_W'(1) == rx_cap) |=> rxf_almost_full_flag && !rxf_full_flag)
      else $error("receive almost-full flag wrong");
   a_rx_almost_empty: assert property (@(posedge clk_in) disable iff (reset_in)
      (!bus_reset_in && rx_count == CNT_W'(1)) |=> rxf_almost_empty_flag && !rxf_empty_flag)
      else $error("receive almost-empty flag wrong");
   a_rx_empty_flag: assert property (@(posedge clk_in) disable iff (reset_in)
      bus_reset_in |=> rxf_empty_flag && rxf_occupancy == '0 && rx_count == '0)
      else $error("bus reset did not empty receive fifo");
   a_first_marker: assert property (@(posedge clk_in) disable iff (reset_in)
      (rx_pop && !bus_reset_in) |=> rxf_first_quadlet_marker == $past(rx_mem[rx_rd][32]))
      else $error("first-quadlet marker wrong");
   a_tx_drop_event: assert property (@(posedge clk_in) disable iff (reset_in)
      (hit_wr && avs_address_in == OFS_TXQ_DATA && tx_count >= tx_cap) |=> int_status[EV_TX_DROP])
      else $error("dropped transmit write not flagged");
   a_bus_reset_clear: assert property (@(posedge clk_in) disable iff (reset_in)
      bus_reset_in |=> s_both_cleared)
      else $error("bus reset left flags or controls set");
   a_irq_level: assert property (@(posedge clk_in) disable iff (reset_in)
      (|(int_status & int_mask)) |=> irq_out)
      else $error("interrupt not raised");
endmodule

// ==== verification/cqf_link_model.sv ====
// Link-side partner: sinks the transmit stream and sources receive quadlets.
// Assumes the bench calls send() and steers stall_in; all timing on rising clk_in.
`timescale 1ns/1ps
module cqf_link_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        stall_in,
   // Transmit stream sink
   input  wire logic [31:0] txq_data_in,
   input  wire logic        txq_valid_in,
   output logic             txq_ready_out,
   // Receive stream source
   output logic      [31:0] rxf_data_out,
   output logic             rxf_first_out,
   output logic             rxf_valid_out,
   input  wire logic        rxf_ready_in
);
   initial begin
      rxf_data_out = 32'h0000_0000;
      rxf_first_out = 1'b0;
      rxf_valid_out = 1'b0;
   end
   // Random ready so the output stage is exercised under back-pressure
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) txq_ready_out <= 1'b0;
      else txq_ready_out <= !stall_in && ($urandom_range(1) == 1);
   end
   // Released lines show the inverse so stale data never looks valid
   task automatic send(input logic [31:0] d, input logic f);
      @(posedge clk_in);
      rxf_data_out <= d;
      rxf_first_out <= f;
      rxf_valid_out <= 1'b1;
      do @(posedge clk_in); while (rxf_ready_in !== 1'b1);
      rxf_valid_out <= 1'b0;
      rxf_data_out <= ~d;
      rxf_first_out <= ~f;
   endtask
endmodule

// ==== verification/command_queue_fifo_status_tb_top.sv ====
// Self-checking bench for the command queue status block over Avalon-MM.
// Assumes the link partner model; expected reads and link words are queued and checked by a watcher.
`timescale 1ns/1ps
module command_queue_fifo_status_tb_top;
   import cqf_pkg::*;
   logic        clk_in = 1'b0, reset_in = 1'b1, bus_reset_in = 1'b0, stall = 1'b1;
   logic [7:0]  avs_address_in = 8'h00;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, txq_data_out, rxf_data_in, w;
   logic        avs_waitrequest_out, txq_valid_out, txq_ready_in, rxf_first_in, rxf_valid_in;
   logic        rxf_ready_out, irq_out;
   logic [31:0] exp_rd[$], exp_tx[$], d[3];
   int          n_errors = 0, samples_checked = 0;

   cqf_top cqf_top_inst (.clk_in(clk_in), .reset_in(reset_in), .bus_reset_in(bus_reset_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .txq_data_out(txq_data_out), .txq_valid_out(txq_valid_out),
      .txq_ready_in(txq_ready_in), .rxf_data_in(rxf_data_in), .rxf_first_in(rxf_first_in),
      .rxf_valid_in(rxf_valid_in), .rxf_ready_out(rxf_ready_out), .irq_out(irq_out));
   cqf_link_model cqf_link_model_inst (.clk_in(clk_in), .reset_in(reset_in), .stall_in(stall),
      .txq_data_in(txq_data_out), .txq_valid_in(txq_valid_out), .txq_ready_out(txq_ready_in),
      .rxf_data_out(rxf_data_in), .rxf_first_out(rxf_first_in), .rxf_valid_out(rxf_valid_in),
      .rxf_ready_in(rxf_ready_out));

   initial forever #2.5 clk_in = ~clk_in;

   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      report(got, exp);
   endtask
   task automatic chk_tx(input logic [31:0] got, input logic [31:0] exp);
      report(got, exp);
   endtask
   task automatic chk_irq(input logic exp);
      report({31'h0, irq_out}, {31'h0, exp});
   endtask
   task automatic close_out();
      // Results still expected at the end never arrived
      if (exp_rd.size() != 0 || exp_tx.size() != 0) n_errors++;
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= dat;
      avs_write_in <= wr_en;
      avs_read_in <= !wr_en;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      bus(1'b1, a, dat);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      exp_rd.push_back(exp);
      bus(1'b0, a, 32'h0000_0000);
      repeat (2) @(posedge clk_in);
   endtask

   // Watcher: a word leaving with nothing queued is a mismatch
   always @(posedge clk_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'b0) chk_rd(avs_readdata_out, exp_rd.pop_front());
      if (txq_valid_out === 1'b1 && txq_ready_in) chk_tx(txq_data_out, exp_tx.size() ? exp_tx.pop_front() : ~txq_data_out);
   end

   initial begin
      #100000;
      n_errors++;
      close_out();
   end

   initial begin
      void'($urandom(32'h25dda26a));
      foreach (d[i]) d[i] = $urandom;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      // Empty queue of fifteen has room for a packet one cycle after reset ends
      rd(OFS_TXQ_STATUS, 32'h1400_000F);
      rd(OFS_RXF_STATUS, 32'h1000_004B);
      rd(OFS_FETCH_CTRL, 32'h0008_0000);
      rd(8'hF0, 32'h0000_0000);
      // Transmit queue shrunk to four quadlets, link stalled; the first word waits in the output stage
      wr(OFS_TXQ_STATUS, 32'h0000_0004);
      for (int i = 0; i < 6; i++) begin
         w = $urandom;
         wr(OFS_TXQ_DATA, w);
         if (i < 5) exp_tx.push_back(w);
         if (i == 1) rd(OFS_TXQ_STATUS, 32'h2400_0004);
         if (i == 3) rd(OFS_TXQ_STATUS, 32'h4000_0004);
         if (i == 4) rd(OFS_TXQ_STATUS, 32'h8000_0004);
      end
      // First word moving to the output stage already emptied the queue once
      rd(OFS_INT_STATUS, 32'h0000_000C);
      wr(OFS_INT_MASK, 32'h0000_0004);
      repeat (3) @(posedge clk_in);
      chk_irq(1'b1);
      wr(OFS_INT_STATUS, 32'h0000_0004);
      repeat (3) @(posedge clk_in);
      chk_irq(1'b0);
      stall <= 1'b0;
      for (int i = 0; i < 300 && exp_tx.size() > 0; i++) @(posedge clk_in);
      repeat (4) @(posedge clk_in);
      rd(OFS_INT_STATUS, 32'h0000_0008);
      wr(OFS_INT_STATUS, 32'h0000_0008);
      // Flush discards queue and output stage
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) wr(OFS_TXQ_DATA, $urandom);
      wr(OFS_TXQ_STATUS, 32'h0000_100F);
      // Flags trail the count by one cycle
      @(posedge clk_in);
      rd(OFS_TXQ_STATUS, 32'h1400_000F);
      stall <= 1'b0;
      repeat (20) @(posedge clk_in);
      // Receive path with first-quadlet marker
      for (int i = 0; i < 3; i++) cqf_link_model_inst.send(d[i], i == 0);
      repeat (3) @(posedge clk_in);
      rd(OFS_RXF_STATUS, 32'h0003_004B);
      rd(OFS_RXF_DATA, d[0]);
      rd(OFS_RXF_STATUS, 32'h0002_804B);
      rd(OFS_RXF_DATA, d[1]);
      rd(OFS_RXF_STATUS, 32'h2001_004B);
      rd(OFS_RXF_DATA, d[2]);
      rd(OFS_RXF_STATUS, 32'h1000_004B);
      rd(OFS_RXF_DATA, 32'h0000_0000);
      // Depth below fetch size is refused
      wr(OFS_RXF_STATUS, 32'h0000_0004);
      rd(OFS_RXF_STATUS, 32'h1000_004B);
      wr(OFS_FETCH_CTRL, 32'h0001_0000);
      wr(OFS_RXF_STATUS, 32'h0000_0002);
      rd(OFS_RXF_STATUS, 32'h1000_0002);
      cqf_link_model_inst.send($urandom, 1'b1);
      repeat (3) @(posedge clk_in);
      rd(OFS_RXF_STATUS, 32'h6001_0002);
      cqf_link_model_inst.send($urandom, 1'b0);
      repeat (3) @(posedge clk_in);
      rd(OFS_RXF_STATUS, 32'h8002_0002);
      wr(OFS_RXF_STATUS, 32'h0000_1002);
      @(posedge clk_in);
      rd(OFS_RXF_STATUS, 32'h1000_0002);
      // Bus reset clears contents, keeps sizes
      cqf_link_model_inst.send($urandom, 1'b1);
      stall <= 1'b1;
      wr(OFS_TXQ_DATA, $urandom);
      repeat (3) @(posedge clk_in);
      bus_reset_in <= 1'b1;
      @(posedge clk_in);
      bus_reset_in <= 1'b0;
      rd(OFS_RXF_STATUS, 32'h1000_0002);
      rd(OFS_TXQ_STATUS, 32'h1400_000F);
      rd(OFS_FETCH_CTRL, 32'h0001_0000);
      stall <= 1'b0;
      repeat (20) @(posedge clk_in);
      close_out();
   end
endmodule
